// File: logic/dcrm_pkg.sv
// Purpose: Shared constants and carriers for the drive communication register bank
// Assumes: 16-bit register words, word-addressed register map
// Notes:   Every address, field position and code lives here once
package dcrm_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [15:0] CMD_ADDR      = 16'h2000;
    localparam logic [15:0] FREQ_ADDR     = 16'h2001;
    localparam logic [15:0] AUX_ADDR      = 16'h2002;
    localparam logic [15:0] STATUS_ADDR   = 16'h2100;
    localparam logic [7:0]  CMD_GROUP     = 8'h20;
    localparam logic [7:0]  CMD_LAST_LOW  = 8'h02;

    // Largest multi-register write, in words
    localparam logic [4:0]  MAX_BURST     = 5'h14;

    ////////////////////////////////////////////////////////////////////////////////
    // Command word fields
    localparam int RUN_LSB    = 0;
    localparam int DIR_LSB    = 4;
    localparam int ACC_LSB    = 6;
    localparam int STEP_LSB   = 8;
    localparam int ENABLE_BIT = 12;

    localparam logic [1:0] RUN_STOP    = 2'h1;
    localparam logic [1:0] RUN_GO      = 2'h2;
    localparam logic [1:0] RUN_INCH    = 2'h3;
    localparam logic [1:0] DIR_FWD     = 2'h1;
    localparam logic [1:0] DIR_REV     = 2'h2;
    localparam logic [1:0] DIR_TOGGLE  = 2'h3;

    // Auxiliary control word fields
    localparam int AUX_EXT_FAULT_BIT  = 0;
    localparam int AUX_RESET_BIT      = 1;
    localparam int AUX_BASE_BLOCK_BIT = 2;
    localparam int AUX_FIRE_BIT       = 5;

    ////////////////////////////////////////////////////////////////////////////////
    // Answer codes
    localparam logic [7:0] EXC_NONE    = 8'h00;
    localparam logic [7:0] EXC_ADDRESS = 8'h02;
    localparam logic [7:0] EXC_VALUE   = 8'h03;

    // Reset values
    localparam logic [15:0] WORD_RESET = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic        write;
        logic [15:0] addr;
        logic [4:0]  count;
    } dcrm_req_s;

    typedef struct packed {
        logic [7:0]  exc;
        logic [15:0] rdata;
    } dcrm_resp_s;

    typedef enum logic [1:0] {
        DCRM_IDLE = 2'b01,
        DCRM_DATA = 2'b10
    } dcrm_state_e;

endpackage : dcrm_pkg

// File: logic/dcrm_register_bank.sv
// Purpose: Register bank behind the serial link of a motor drive
// Assumes: A frame decoder on the same clock delivers requests and data words
// Notes:   Parameter store, command words and status word in one module
//
// Overview of operation
// - A parameter sits at address group_number_address: group in the high byte, number in the low.
// - Command bits 1-0: 00 nothing, 01 stop, 10 run, 11 run with inching.
// - Command bits 5-4: 00 nothing, 01 forward, 10 reverse, 11 toggle direction.
// - Command bits 7-6 pick one of four accel/decel sets.
// - Command bits 11-8 pick master speed (0000) or step speed 1 to 15.
// - Command bit 12 must be set for bits 6 to 11 to take effect.
// - Aux word: bit 0 external fault, bit 1 fault reset, bit 2 base block, bit 5 fire mode.
// - Status word 0x2100 reads warning code high byte and fault code low byte.
// - Status words are read only and command words are write only.
// - A write covers one register or up to twenty consecutive registers.
`timescale 1ns/100ps
`default_nettype none

module dcrm_register_bank #(
    parameter int GROUPS    = 15,
    parameter int PER_GROUP = 64
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // Request from the frame decoder
    input  wire logic               req_valid,
    input  wire dcrm_pkg::dcrm_req_s req,
    output logic                    req_ready,
    // Write data words
    input  wire logic               data_valid,
    input  wire logic [15:0]        data_word,
    output logic                    data_ready,
    // Answer to the frame encoder
    output logic                    resp_valid,
    output dcrm_pkg::dcrm_resp_s    resp,
    // Drive state shown to the master
    input  wire logic [7:0]         warning_code,
    input  wire logic [7:0]         fault_code,
    // Drive controls
    output logic                    run_active,
    output logic                    inching_run,
    output logic                    reverse_rotation,
    output logic [1:0]              accdec_set,
    output logic [3:0]              step_select,
    output logic [15:0]             freq_setpoint,
    output logic                    ext_fault,
    output logic                    fault_reset,
    output logic                    base_block,
    output logic                    fire_mode
);

    localparam int DEPTH = GROUPS * PER_GROUP;
    localparam int IDX_W = $clog2(DEPTH);

    ////////////////////////////////////////////////////////////////////////////////
    // State
    dcrm_pkg::dcrm_state_e state_reg;
    logic [15:0]           addr_reg;
    logic [4:0]            left_reg;
    logic                  param_reg;
    logic [15:0]           param_mem [DEPTH];

    ////////////////////////////////////////////////////////////////////////////////
    // Request decode
    wire logic        take_req   = req_valid && (state_reg == dcrm_pkg::DCRM_IDLE);
    wire logic [15:0] last_addr  = req.addr + {11'h000, req.count} - 16'h0001;
    wire logic        count_ok   = (req.count != 5'h00) &&
                                   (req.write ? (req.count <= dcrm_pkg::MAX_BURST)
                                              : (req.count == 5'h01));
    // Range must stay inside one group, so an address carry never wraps into the next
    wire logic        param_ok   = ({24'h0, req.addr[15:8]} < GROUPS) &&
                                   (last_addr[15:8] == req.addr[15:8]) &&
                                   ({24'h0, last_addr[7:0]} < PER_GROUP);
    wire logic        cmd_ok     = req.write && (req.addr[15:8] == dcrm_pkg::CMD_GROUP) &&
                                   (last_addr[15:8] == dcrm_pkg::CMD_GROUP) &&
                                   (last_addr[7:0] <= dcrm_pkg::CMD_LAST_LOW);
    wire logic        stat_ok    = !req.write && (req.addr == dcrm_pkg::STATUS_ADDR);
    wire logic [7:0]  req_exc    = !count_ok ? dcrm_pkg::EXC_VALUE :
                                   !(param_ok || cmd_ok || stat_ok) ?
                                   dcrm_pkg::EXC_ADDRESS : dcrm_pkg::EXC_NONE;
    wire logic        req_good   = (req_exc == dcrm_pkg::EXC_NONE);
    wire logic        start_wr   = take_req && req_good && req.write;

    // Word-level write decode
    wire logic        take_word  = data_valid && (state_reg == dcrm_pkg::DCRM_DATA);
    wire logic        last_word  = take_word && (left_reg == 5'h01);
    wire logic        wr_cmd     = take_word && !param_reg && (addr_reg == dcrm_pkg::CMD_ADDR);
    wire logic        wr_freq    = take_word && !param_reg && (addr_reg == dcrm_pkg::FREQ_ADDR);
    wire logic        wr_aux     = take_word && !param_reg && (addr_reg == dcrm_pkg::AUX_ADDR);
    wire logic [IDX_W-1:0] wr_idx = IDX_W'(({24'h0, addr_reg[15:8]} * PER_GROUP) +
                                           {24'h0, addr_reg[7:0]});
    wire logic [IDX_W-1:0] rd_idx = IDX_W'(({24'h0, req.addr[15:8]} * PER_GROUP) +
                                           {24'h0, req.addr[7:0]});

    // Command word fields
    wire logic [1:0]  run_field  = data_word[dcrm_pkg::RUN_LSB  +: 2];
    wire logic [1:0]  dir_field  = data_word[dcrm_pkg::DIR_LSB  +: 2];
    wire logic        sel_enable = data_word[dcrm_pkg::ENABLE_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // Transfer sequencing
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= dcrm_pkg::DCRM_IDLE;
            addr_reg  <= dcrm_pkg::WORD_RESET;
            left_reg  <= 5'h00;
            param_reg <= 1'b0;
        end else if (start_wr) begin
            state_reg <= dcrm_pkg::DCRM_DATA;
            addr_reg  <= req.addr;
            left_reg  <= req.count;
            param_reg <= param_ok && !cmd_ok;
        end else if (take_word) begin
            addr_reg  <= addr_reg + 16'h0001;           // Consecutive registers
            left_reg  <= left_reg - 5'h01;
            if (last_word) begin
                state_reg <= dcrm_pkg::DCRM_IDLE;
            end
        end
    end

    // Handshake readies follow the state register directly
    assign req_ready  = (state_reg == dcrm_pkg::DCRM_IDLE);
    assign data_ready = (state_reg == dcrm_pkg::DCRM_DATA);

    ////////////////////////////////////////////////////////////////////////////////
    // Parameter store; left without reset, a large array needs no defined power-up
    always_ff @(posedge clk) begin
        if (take_word && param_reg) begin
            param_mem[wr_idx] <= data_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Answers: refused or read requests answer one cycle after the request,
    // writes one cycle after the last data word
    always_ff @(posedge clk) begin
        if (rst) begin
            resp_valid <= 1'b0;
            resp       <= '0;
        end else begin
            resp_valid <= (take_req && !start_wr) || last_word;
            if (take_req && !start_wr) begin
                resp.exc <= req_exc;
                if (!req_good) begin
                    resp.rdata <= dcrm_pkg::WORD_RESET;
                end else if (stat_ok) begin
                    resp.rdata <= {warning_code, fault_code};
                end else begin
                    resp.rdata <= param_mem[rd_idx];
                end
            end else if (last_word) begin
                resp.exc   <= dcrm_pkg::EXC_NONE;
                resp.rdata <= dcrm_pkg::WORD_RESET;     // Write-only words never echo back
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Run and direction commands; bits 3-2 and 15-13 are simply never looked at
    always_ff @(posedge clk) begin
        if (rst) begin
            run_active       <= 1'b0;
            inching_run      <= 1'b0;
            reverse_rotation <= 1'b0;
        end else if (wr_cmd) begin
            unique case (run_field)
                dcrm_pkg::RUN_STOP: begin
                    run_active  <= 1'b0;
                    inching_run <= 1'b0;
                end
                dcrm_pkg::RUN_GO: begin
                    run_active  <= 1'b1;
                    inching_run <= 1'b0;
                end
                dcrm_pkg::RUN_INCH: begin
                    run_active  <= 1'b1;
                    inching_run <= 1'b1;
                end
                default: begin
                end
            endcase
            unique case (dir_field)
                dcrm_pkg::DIR_FWD:    reverse_rotation <= 1'b0;
                dcrm_pkg::DIR_REV:    reverse_rotation <= 1'b1;
                dcrm_pkg::DIR_TOGGLE: reverse_rotation <= !reverse_rotation;
                default: begin
                end
            endcase
        end
    end

    // Speed and ramp selection only move when the enable bit rides along
    always_ff @(posedge clk) begin
        if (rst) begin
            accdec_set  <= 2'h0;
            step_select <= 4'h0;
        end else if (wr_cmd && sel_enable) begin
            accdec_set  <= data_word[dcrm_pkg::ACC_LSB  +: 2];
            step_select <= data_word[dcrm_pkg::STEP_LSB +: 4];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Frequency setpoint, held as written in 0.01 Hz units
    always_ff @(posedge clk) begin
        if (rst) begin
            freq_setpoint <= dcrm_pkg::WORD_RESET;
        end else if (wr_freq) begin
            freq_setpoint <= data_word;
        end
    end

    // Auxiliary controls; fault reset is a request, so it lasts one cycle only
    always_ff @(posedge clk) begin
        if (rst) begin
            ext_fault   <= 1'b0;
            fault_reset <= 1'b0;
            base_block  <= 1'b0;
            fire_mode   <= 1'b0;
        end else begin
            fault_reset <= wr_aux && data_word[dcrm_pkg::AUX_RESET_BIT];
            if (wr_aux) begin
                ext_fault  <= data_word[dcrm_pkg::AUX_EXT_FAULT_BIT];
                base_block <= data_word[dcrm_pkg::AUX_BASE_BLOCK_BIT];
                fire_mode  <= data_word[dcrm_pkg::AUX_FIRE_BIT];
            end
        end
    end

endmodule : dcrm_register_bank

`default_nettype wire

// File: test/dcrm_register_bank_assertions.sv
// Purpose: Port assertions for the register bank
// Assumes: One clock, synchronous reset
// Notes:   Bound to every register bank instance
`timescale 1ns/100ps
`default_nettype none
module dcrm_register_bank_assertions (
    // Clock and reset
    input wire logic                 clk,
    input wire logic                 rst,
    // Request and answer
    input wire logic                 req_valid,
    input wire dcrm_pkg::dcrm_req_s  req,
    input wire logic                 req_ready,
    input wire logic                 data_ready,
    input wire logic                 resp_valid,
    input wire dcrm_pkg::dcrm_resp_s resp,
    // Status inputs and pulse output
    input wire logic [7:0]           warning_code,
    input wire logic [7:0]           fault_code,
    input wire logic                 fault_reset
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    //////////////////////////////////////////////////////////////////////
    // A request of one kind taken at this edge
    sequence s_take(w, a, c);
        req_valid && req_ready && req.write == w && req.addr == a && req.count == c;
    endsequence
    status_read_a: assert property (s_take(1'b0, 16'h2100, 5'h01) |=>
        resp_valid && resp.exc == 8'h00 && resp.rdata == {$past(warning_code), $past(fault_code)})
        else $error("status read answer wrong");
    status_write_a: assert property (s_take(1'b1, 16'h2100, 5'h01) |=>
        resp_valid && resp.exc == 8'h02) else $error("status write not refused");
    cmd_read_a: assert property (s_take(1'b0, 16'h2000, 5'h01) |=>
        resp_valid && resp.exc == 8'h02) else $error("command read not refused");
    burst_limit_a: assert property (s_take(1'b1, 16'h0400, 5'h15) |=>
        resp_valid && resp.exc == 8'h03) else $error("long burst not refused");
    data_phase_a: assert property (s_take(1'b1, 16'h2000, 5'h01) |=>
        data_ready && !req_ready) else $error("no data phase after write");
    // A request taken while an answer pulses may answer at the very next edge
    resp_pulse_a: assert property (resp_valid && !(req_valid && req_ready) |=>
        !resp_valid) else $error("answer longer than one cycle");
    reset_pulse_a: assert property ($rose(fault_reset) |=> !fault_reset)
        else $error("fault reset not a pulse");
    phase_excl_a: assert property (!(req_ready && data_ready))
        else $error("request and data phase overlap");
endmodule : dcrm_register_bank_assertions
bind dcrm_register_bank dcrm_register_bank_assertions i_chk (.clk, .rst, .req_valid, .req,
    .req_ready, .data_ready, .resp_valid, .resp, .warning_code, .fault_code, .fault_reset);
`default_nettype wire

// File: test/dcrm_master_model.sv
// Purpose: Serial master side that issues requests and write words
// Assumes: Signals change 1 ns after a rising edge
// Notes:   A wait that runs out raises stuck
`timescale 1ns/100ps
`default_nettype none
module dcrm_master_model (
    // Clock
    input wire logic             clk,
    // Toward the bank, and the stuck flag for the bench
    output logic                 req_valid,
    output dcrm_pkg::dcrm_req_s  req,
    output logic                 data_valid,
    output logic [15:0]          data_word,
    output logic                 stuck,
    // From the bank
    input wire logic             req_ready,
    input wire logic             data_ready
);
    initial begin
        req_valid = 1'b0;
        req = '0;
        data_valid = 1'b0;
        data_word = 16'h0000;
        stuck = 1'b0;
    end
    // Hold until ready is seen high at an edge; bounded so a hang is caught
    task automatic wait_ready(input logic on_data);
        int n;
        n = 0;
        while (!(on_data ? data_ready : req_ready) && n < 100) begin
            @(posedge clk);
            #1 n++;
        end
        if (n == 100) stuck = 1'b1;
        @(posedge clk);
        #1;
    endtask : wait_ready
    // Released lines show the inverse, never a stale copy
    task automatic request(input logic w, input logic [15:0] a, input logic [4:0] c);
        req_valid = 1'b1;
        req = {w, a, c};
        wait_ready(1'b0);
        req_valid = 1'b0;
        req = ~req;
    endtask : request
    // Words back to back, one per register in address order
    task automatic send(input logic [15:0] w[20], input int n);
        data_valid = 1'b1;
        for (int i = 0; i < n; i++) begin
            data_word = w[i];
            wait_ready(1'b1);
        end
        data_valid = 1'b0;
        data_word = ~data_word;
    endtask : send
endmodule : dcrm_master_model
`default_nettype wire

// File: test/dcrm_register_bank_test.sv
// Purpose: Self-checking bench for the register bank
// Assumes: 50 MHz clock, master model drives requests
// Notes:   Expected values come from the field codes
`timescale 1ns/100ps
`default_nettype none
module dcrm_register_bank_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid, req_ready, data_valid, data_ready, resp_valid, stuck;
    dcrm_pkg::dcrm_req_s  req;
    dcrm_pkg::dcrm_resp_s resp;
    logic [15:0] data_word, freq_setpoint;
    logic [7:0]  warning_code = 8'hA5;
    logic [7:0]  fault_code = 8'h3C;
    logic run_active, inching_run, reverse_rotation, ext_fault, fault_reset, base_block, fire_mode;
    logic [1:0]  accdec_set;
    logic [3:0]  step_select;
    logic [15:0] words[20];
    logic [15:0] cmd_tab[5] = '{16'h1BE2, 16'hEFFF, 16'h1011, 16'h0020, 16'h1F40};
    logic [8:0]  ctl_tab[5] = '{9'h17B, 9'h1BB, 9'h000, 9'h040, 9'h05F};
    int bad_count = 0;
    int n_tests = 0;
    always #10 clk = ~clk;
    dcrm_register_bank i_dut (.clk, .rst, .req_valid, .req, .req_ready, .data_valid,
        .data_word, .data_ready, .resp_valid, .resp, .warning_code, .fault_code, .run_active,
        .inching_run, .reverse_rotation, .accdec_set, .step_select, .freq_setpoint,
        .ext_fault, .fault_reset, .base_block, .fire_mode);
    dcrm_master_model i_master (.clk, .req_valid, .req, .data_valid, .data_word, .stuck,
        .req_ready, .data_ready);
    //////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (bad_count == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run
    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", nm, exp, got);
            bad_count++;
        end
    endtask : check
    // Request, words of a good write, then the one-cycle answer
    task automatic xfer(input logic w, input logic [15:0] a, input logic [4:0] c, input int n,
                        input logic [7:0] exc, input logic [15:0] rd);
        int k;
        k = 0;
        i_master.request(w, a, c);
        if (n > 0) i_master.send(words, n);
        while (resp_valid !== 1'b1 && k < 100) begin
            @(posedge clk);
            #1 k++;
        end
        // A missing answer is a mismatch of its own and ends the run
        if (k == 100) begin
            $display("Error resp_valid expected 1 seen 0");
            bad_count++;
            complete_run();
        end else begin
            check("resp.exc", {8'h00, exc}, {8'h00, resp.exc});
            if (exc == 8'h00) check("resp.rdata", rd, resp.rdata);
        end
    endtask : xfer
    // A hang in the master model ends the run
    always @(posedge stuck) begin
        $display("Error ready expected 1 seen 0");
        bad_count++;
        complete_run();
    end
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        check("req_ready", 16'h0001, {15'h0, req_ready});
        words[0] = 16'h1BE2;
        words[1] = 16'h1770;
        words[2] = 16'h0027;
        xfer(1'b1, 16'h2000, 5'h03, 3, 8'h00, 16'h0000);
        check("freq_setpoint", 16'h1770, freq_setpoint);
        check("aux levels", 16'h0007, {13'h0, ext_fault, base_block, fire_mode});
        check("fault_reset", 16'h0001, {15'h0, fault_reset});
        @(posedge clk);
        #1 check("fault_reset", 16'h0000, {15'h0, fault_reset});
        // Last entry leaves run and direction alone but moves ramp and step
        for (int i = 0; i < 5; i++) begin
            words[0] = cmd_tab[i];
            xfer(1'b1, 16'h2000, 5'h01, 1, 8'h00, 16'h0000);
            check("drive controls", {7'h0, ctl_tab[i]}, {7'h0, run_active, inching_run,
                reverse_rotation, accdec_set, step_select});
        end
        xfer(1'b0, 16'h2100, 5'h01, 0, 8'h00, 16'hA53C);
        words[0] = 16'h1388;
        words[1] = 16'h0FA0;
        xfer(1'b1, 16'h040A, 5'h02, 2, 8'h00, 16'h0000);
        xfer(1'b0, 16'h040B, 5'h01, 0, 8'h00, 16'h0FA0);
        for (int i = 0; i < 20; i++) begin
            words[i] = 16'h1000 + 16'(i);
        end
        xfer(1'b1, 16'h0400, 5'h14, 20, 8'h00, 16'h0000);
        xfer(1'b0, 16'h0413, 5'h01, 0, 8'h00, 16'h1013);
        xfer(1'b1, 16'h0400, 5'h15, 0, 8'h03, 16'h0000);
        xfer(1'b0, 16'h0400, 5'h01, 0, 8'h00, 16'h1000);
        xfer(1'b0, 16'h2000, 5'h01, 0, 8'h02, 16'h0000);
        xfer(1'b1, 16'h2100, 5'h01, 0, 8'h02, 16'h0000);
        xfer(1'b0, 16'h0100, 5'h02, 0, 8'h03, 16'h0000);
        xfer(1'b0, 16'h0F00, 5'h01, 0, 8'h02, 16'h0000);
        complete_run();
    end
endmodule : dcrm_register_bank_test
`default_nettype wire
